/* File: core/ptr_params.svh */
// constants for the telemetry readback link: command codes, fields, timing
// assumes a 40 MHz core clock shared by both ends
`ifndef PTR_PARAMS_SVH
`define PTR_PARAMS_SVH

`define PTR_CMD_PAGE        8'h00
`define PTR_CMD_CLEAR       8'h03
`define PTR_CMD_PHASE       8'h04
`define PTR_CMD_STATUS_WORD 8'h79
`define PTR_CMD_STATUS_CML  8'h7E
`define PTR_CMD_IIN         8'h89
`define PTR_CMD_VOUT        8'h8B
`define PTR_CMD_IOUT        8'h8C
`define PTR_CMD_TEMP        8'h8D
`define PTR_CMD_POUT        8'h96

`define PTR_PAGE_A          8'h00
`define PTR_PAGE_B          8'h01
`define PTR_PAGE_ALL        8'hFF
`define PTR_PHASE_ALL       8'hFF
`define PTR_PHASE_SUM       8'h80
`define PTR_PAGE_RESET      8'h00
`define PTR_PHASE_RESET     8'h00

`define PTR_EXP_MSB         15
`define PTR_EXP_LSB         11
`define PTR_MAN_MSB         10
`define PTR_MAN_LSB         0
`define PTR_VID_MSB         7
`define PTR_CML_BIT_WORD    1
`define PTR_CML_BIT_DATA    6
`define PTR_CML_BIT_CMD     7

`define PTR_PHASES          3
`define PTR_CLK_MHZ         40
`define PTR_IIN_REFRESH_US  100
`define PTR_SLOW_REFRESH_US 1200
`define PTR_IIN_CYCLES      (`PTR_IIN_REFRESH_US * `PTR_CLK_MHZ)
`define PTR_SLOW_CYCLES     (`PTR_SLOW_REFRESH_US * `PTR_CLK_MHZ)

`endif

/* File: core/ptr_pkg.sv */
// types shared by the telemetry device end and the host end
// assumes ptr_params.svh is on the include path
`include "ptr_params.svh"
package ptr_pkg;
  typedef logic [15:0] ptr_word_t;

  typedef struct packed {
    logic [7:0]                     page;
    logic [7:0]                     phase;
    logic [15:0]                    iin_tmr;
    logic [15:0]                    slow_tmr;
    ptr_word_t                      iin;
    logic [7:0]                     vout_a;
    logic [7:0]                     vout_b;
    logic [`PTR_PHASES-1:0][15:0]   iout_a_ph;
    ptr_word_t                      iout_a_sum;
    ptr_word_t                      iout_b;
    ptr_word_t                      temp_a;
    ptr_word_t                      temp_b;
    ptr_word_t                      pout_a;
    ptr_word_t                      pout_b;
    logic [7:0]                     cml;
    logic                           rsp_valid;
    logic                           rsp_err;
    ptr_word_t                      rsp_data;
  } ptr_dev_state_t;

  typedef enum logic [1:0] {
    PTR_H_IDLE = 2'b00,
    PTR_H_REQ  = 2'b01,
    PTR_H_WAIT = 2'b10
  } ptr_host_fsm_t;

  typedef struct packed {
    ptr_host_fsm_t fsm;
    logic          write;
    logic [7:0]    code;
    ptr_word_t     wdata;
    ptr_word_t     rdata;
    logic          err;
    logic          done;
  } ptr_host_state_t;
endpackage

/* File: core/ptr_link_if.sv */
// command link between the telemetry host end and the device end
// assumes both ends run on the same clock and reset
`timescale 1ns/100ps
interface ptr_link_if
(
  input wire logic clk_i,
  input wire logic reset_n_i
);
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic        rsp_err;
  logic [15:0] rsp_data;
  logic        alert_n;

  modport device
  (
    input  cmd_valid, cmd_write, cmd_code, cmd_wdata,
    output cmd_ready, rsp_valid, rsp_err, rsp_data, alert_n
  );
  modport host
  (
    output cmd_valid, cmd_write, cmd_code, cmd_wdata,
    input  cmd_ready, rsp_valid, rsp_err, rsp_data, alert_n
  );
endinterface // ptr_link_if

/* File: core/ptr_device.sv */
// telemetry readback device end: refresh snapshots, paging, phases, fault flag
// assumes telemetry samples come from logic on clk_i, the link from the host end
`timescale 1ns/100ps
`include "ptr_params.svh"
module ptr_device
#(
  parameter int SLOW_CYCLES = `PTR_SLOW_CYCLES
)
(
  input  wire logic                           clk_i,
  input  wire logic                           reset_n_i,
  ptr_link_if.device                          link,
  input  wire logic [15:0]                    iin_sample_i,
  input  wire logic [7:0]                     vout_code_a_i,
  input  wire logic [7:0]                     vout_code_b_i,
  input  wire logic [`PTR_PHASES-1:0][15:0]   iout_a_phase_i,
  input  wire logic [15:0]                    iout_a_sum_i,
  input  wire logic [15:0]                    iout_b_i,
  input  wire logic [15:0]                    temp_hot_a_i,
  input  wire logic [15:0]                    temp_hot_b_i,
  input  wire logic [15:0]                    pout_a_i,
  input  wire logic [15:0]                    pout_b_i,
  output logic                                iin_tick_o,
  output logic                                slow_tick_o,
  output logic                                host_alert_output_o
);
  localparam logic [15:0] IIN_RELOAD  = 16'(`PTR_IIN_CYCLES - 1);
  localparam logic [15:0] SLOW_RELOAD = 16'(SLOW_CYCLES - 1);

  ptr_pkg::ptr_dev_state_t s_reg;
  ptr_pkg::ptr_dev_state_t s_next;

  logic       iin_tick;
  logic       slow_tick;
  logic       page_a;
  logic       page_b;
  logic [7:0] code;
  logic       known;
  logic       ro_cmd;

  assign iin_tick  = (s_reg.iin_tmr == 16'h0000);
  assign slow_tick = (s_reg.slow_tmr == 16'h0000);
  assign page_a = (s_reg.page == `PTR_PAGE_A);
  assign page_b = (s_reg.page == `PTR_PAGE_B);
  assign code   = link.cmd_code;

  always_comb
  begin
    ro_cmd = 1'b0;
    known  = 1'b1;
    unique case (code)
      `PTR_CMD_IIN, `PTR_CMD_VOUT, `PTR_CMD_IOUT, `PTR_CMD_TEMP, `PTR_CMD_POUT,
      `PTR_CMD_STATUS_WORD, `PTR_CMD_STATUS_CML:
        ro_cmd = 1'b1;
      `PTR_CMD_PAGE, `PTR_CMD_PHASE, `PTR_CMD_CLEAR:
        ro_cmd = 1'b0;
      default:
        known = 1'b0;
    endcase
  end

  function automatic ptr_pkg::ptr_word_t read_value(input ptr_pkg::ptr_dev_state_t st,
                                                    input logic [7:0] c,
                                                    input logic pa,
                                                    input logic pb);
    ptr_pkg::ptr_word_t v;
    v = 16'h0000;
    unique case (c)
      `PTR_CMD_PAGE:
        v = {8'h00, st.page};
      `PTR_CMD_PHASE:
        v = {8'h00, st.phase};
      `PTR_CMD_IIN:
        v = st.iin;
      `PTR_CMD_VOUT:
        v = {8'h00, (pb ? st.vout_b : st.vout_a)};
      `PTR_CMD_IOUT:
      begin
        if (pb)
          v = st.iout_b;
        else if (st.phase == `PTR_PHASE_SUM || st.phase == `PTR_PHASE_ALL)
          v = st.iout_a_sum;
        else if (st.phase < 8'(`PTR_PHASES))
          v = st.iout_a_ph[st.phase[1:0]];
        else
          v = 16'h0000;
      end
      `PTR_CMD_TEMP:
        v = pb ? st.temp_b : st.temp_a;
      `PTR_CMD_POUT:
        v = pb ? st.pout_b : st.pout_a;
      `PTR_CMD_STATUS_WORD:
        v = {14'h0000, (st.cml != 8'h00), 1'b0};
      `PTR_CMD_STATUS_CML:
        v = {8'h00, st.cml};
      default:
        v = 16'h0000;
    endcase
    if (!pa && !pb && st.page != `PTR_PAGE_ALL)
      v = (c == `PTR_CMD_PAGE || c == `PTR_CMD_IIN || c == `PTR_CMD_STATUS_WORD
           || c == `PTR_CMD_STATUS_CML || c == `PTR_CMD_PHASE) ? v : 16'h0000;
    return v;
  endfunction

  always_comb
  begin
    s_next           = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_err   = 1'b0;
    if (iin_tick)
    begin
      s_next.iin_tmr = IIN_RELOAD;
      s_next.iin     = iin_sample_i;
    end
    else
      s_next.iin_tmr = s_reg.iin_tmr - 16'h0001;
    if (slow_tick)
    begin
      s_next.slow_tmr   = SLOW_RELOAD;
      s_next.vout_a     = vout_code_a_i;
      s_next.vout_b     = vout_code_b_i;
      s_next.iout_a_ph  = iout_a_phase_i;
      s_next.iout_a_sum = iout_a_sum_i;
      s_next.iout_b     = iout_b_i;
      s_next.temp_a     = temp_hot_a_i;
      s_next.temp_b     = temp_hot_b_i;
      s_next.pout_a     = pout_a_i;
      s_next.pout_b     = pout_b_i;
    end
    else
      s_next.slow_tmr = s_reg.slow_tmr - 16'h0001;
    if (link.cmd_valid)
    begin
      s_next.rsp_valid = 1'b1;
      s_next.rsp_data  = 16'h0000;
      if (!known)
      begin
        s_next.rsp_err                    = 1'b1;
        s_next.cml[`PTR_CML_BIT_CMD]      = 1'b1;
      end
      else if (link.cmd_write)
      begin
        if (ro_cmd)
        begin
          s_next.rsp_err               = 1'b1;
          s_next.cml[`PTR_CML_BIT_DATA] = 1'b1;
        end
        else if (code == `PTR_CMD_PAGE)
          s_next.page = link.cmd_wdata[7:0];
        else if (code == `PTR_CMD_PHASE)
          s_next.phase = link.cmd_wdata[7:0];
        else
          s_next.cml = 8'h00;
      end
      else
        s_next.rsp_data = read_value(s_reg, code, page_a, page_b);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_reg          <= '0;
      s_reg.page     <= `PTR_PAGE_RESET;
      s_reg.phase    <= `PTR_PHASE_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign link.cmd_ready      = 1'b1;
  assign link.rsp_valid      = s_reg.rsp_valid;
  assign link.rsp_err        = s_reg.rsp_err;
  assign link.rsp_data       = s_reg.rsp_data;
  assign link.alert_n        = (s_reg.cml == 8'h00);
  assign host_alert_output_o = (s_reg.cml != 8'h00);
  assign iin_tick_o          = iin_tick;
  assign slow_tick_o         = slow_tick;
endmodule // ptr_device

/* File: core/ptr_host.sv */
// telemetry host end: issues one word command at a time over the link
// assumes the device end answers every taken command with one response
`timescale 1ns/100ps
`include "ptr_params.svh"
module ptr_host
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  ptr_link_if.host         link,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [7:0]  code_i,
  input  wire logic [15:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             err_o,
  output logic [15:0]      rdata_o,
  output logic             alert_o
);
  ptr_pkg::ptr_host_state_t s_reg;
  ptr_pkg::ptr_host_state_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.fsm)
      ptr_pkg::PTR_H_IDLE:
        if (start_i)
        begin
          s_next.fsm   = ptr_pkg::PTR_H_REQ;
          s_next.write = write_i;
          s_next.code  = code_i;
          s_next.wdata = wdata_i;
        end
      ptr_pkg::PTR_H_REQ:
        if (link.cmd_ready)
          s_next.fsm = ptr_pkg::PTR_H_WAIT;
      ptr_pkg::PTR_H_WAIT:
        if (link.rsp_valid)
        begin
          s_next.rdata = link.rsp_data;
          s_next.err   = link.rsp_err;
          s_next.done  = 1'b1;
          s_next.fsm   = ptr_pkg::PTR_H_IDLE;
        end
      default:
        s_next.fsm = ptr_pkg::PTR_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // page and phase sent as commanded
  assign link.cmd_valid = (s_reg.fsm == ptr_pkg::PTR_H_REQ);
  assign link.cmd_write = s_reg.write;
  assign link.cmd_code  = s_reg.code;
  assign link.cmd_wdata = s_reg.wdata;
  assign busy_o         = (s_reg.fsm != ptr_pkg::PTR_H_IDLE);
  assign done_o         = s_reg.done;
  assign err_o          = s_reg.err;
  assign rdata_o        = s_reg.rdata;
  assign alert_o        = ~link.alert_n;
endmodule // ptr_host

/* File: dv/ptr_link_assertions.sv */
// checker for the link between host end and device end
// assumes one clock domain, reset active low
`timescale 1ns/100ps
module ptr_link_assertions
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic        rsp_err,
  input wire logic [15:0] rsp_data,
  input wire logic        alert_n
);
  logic ro_wr;
  logic clr;
  logic rd;
  assign ro_wr = cmd_valid && cmd_write && (cmd_code inside {8'h79, 8'h7e, 8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h96});
  assign clr = cmd_valid && cmd_write && cmd_code == 8'h03;
  assign rd = cmd_valid && !cmd_write;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rsp; cmd_valid && cmd_ready |=> rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("command without answer");
  property p_idle; !cmd_valid |=> !rsp_valid; endproperty
  a_idle: assert property (p_idle) else $error("answer without command");
  property p_ro; ro_wr |=> rsp_err && !alert_n && rsp_data == 16'h0000; endproperty
  a_ro: assert property (p_ro) else $error("write to reading accepted");
  property p_hold; !alert_n && !clr |=> !alert_n; endproperty
  a_hold: assert property (p_hold) else $error("alert dropped without clear");
  property p_clr; clr |=> alert_n; endproperty
  a_clr: assert property (p_clr) else $error("alert kept after clear");
  property p_vout; rd && cmd_code == 8'h8b |=> rsp_data[15:8] == 8'h00 && !rsp_err; endproperty
  a_vout: assert property (p_vout) else $error("voltage code high byte set");
  property p_rdok; rd && (cmd_code inside {8'h89, 8'h8c, 8'h8d, 8'h96}) |=> !rsp_err; endproperty
  a_rdok: assert property (p_rdok) else $error("reading refused");
  property p_fell; $fell(alert_n) |-> $past(cmd_valid); endproperty
  a_fell: assert property (p_fell) else $error("alert without command");
endmodule // ptr_link_assertions

/* File: dv/pmbus_telemetry_readback_tb.sv */
// bench: host end and device end joined by the link, a model checks every answer
// assumes the core files compiled first, 40 MHz clock
`timescale 1ns/100ps
`include "ptr_params.svh"
module pmbus_telemetry_readback_tb;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        start_i = 1'b0;
  logic        write_i = 1'b0;
  logic [7:0]  code_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] tv [11];
  logic [15:0] iin, s_iin, rnd, ci, cs, rdata_o;
  logic [7:0]  m_page, m_phase, m_cml;
  logic        busy_o, done_o, err_o, alert_o, iin_tick_o, slow_tick_o, host_alert_output_o;
  int          fails, cmp_count;
  logic [7:0]  pg [4] = '{8'h00, 8'h01, 8'hff, 8'h02};
  logic [7:0]  rd [5] = '{8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h96};
  logic [7:0]  phs [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80, 8'hff};
  logic [7:0]  ro [7] = '{8'h79, 8'h7e, 8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h96};

  always #12.5 clk_i = ~clk_i;

  ptr_link_if u_ptr_link_if (.clk_i(clk_i), .reset_n_i(reset_n_i));
  ptr_device #(.SLOW_CYCLES(8)) u_ptr_device (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(u_ptr_link_if.device),
    .iin_sample_i(iin), .vout_code_a_i(tv[0][7:0]), .vout_code_b_i(tv[1][7:0]),
    .iout_a_phase_i({tv[4], tv[3], tv[2]}), .iout_a_sum_i(tv[5]), .iout_b_i(tv[6]), .temp_hot_a_i(tv[7]),
    .temp_hot_b_i(tv[8]), .pout_a_i(tv[9]), .pout_b_i(tv[10]), .iin_tick_o(iin_tick_o),
    .slow_tick_o(slow_tick_o), .host_alert_output_o(host_alert_output_o));
  ptr_host u_ptr_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(u_ptr_link_if.host), .start_i(start_i),
    .write_i(write_i), .code_i(code_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
    .rdata_o(rdata_o), .alert_o(alert_o));
  ptr_link_assertions u_ptr_link_assertions (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .cmd_valid(u_ptr_link_if.cmd_valid), .cmd_ready(u_ptr_link_if.cmd_ready), .cmd_write(u_ptr_link_if.cmd_write),
    .cmd_code(u_ptr_link_if.cmd_code), .cmd_wdata(u_ptr_link_if.cmd_wdata), .rsp_valid(u_ptr_link_if.rsp_valid),
    .rsp_err(u_ptr_link_if.rsp_err), .rsp_data(u_ptr_link_if.rsp_data), .alert_n(u_ptr_link_if.alert_n));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [15:0] model(input logic [7:0] c);
    logic b, a;
    b = m_page == 8'h01;
    a = m_page == 8'h00 || m_page == 8'hff;
    case (c)
      8'h00: return {8'h00, m_page};
      8'h04: return {8'h00, m_phase};
      8'h79: return {14'h0000, |m_cml, 1'b0};
      8'h7e: return {8'h00, m_cml};
      8'h89: return s_iin;
      8'h8b: return b ? {8'h00, tv[1][7:0]} : a ? {8'h00, tv[0][7:0]} : 16'h0000;
      8'h8c: return b ? tv[6] : !a ? 16'h0000 : (m_phase == 8'h80 || m_phase == 8'hff) ? tv[5] :
                    (m_phase < 8'h03) ? tv[2 + m_phase] : 16'h0000;
      8'h8d: return b ? tv[8] : a ? tv[7] : 16'h0000;
      8'h96: return b ? tv[10] : a ? tv[9] : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1)
    begin
      if (n == lim)
      begin
        fails++;
        $display("wait ran out at %0t", $time);
        end_sim();
      end
      @(posedge clk_i);
      #2;
      n++;
    end
  endtask

  task automatic roll;
    for (int i = 0; i < 11; i++)
    begin
      rnd = lfsr(rnd);
      tv[i] = rnd;
    end
  endtask

  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
    logic roc, er;
    logic [15:0] e;
    roc = c inside {ro};
    er = (w && roc) || !(roc || c inside {8'h00, 8'h03, 8'h04});
    e = (w || er) ? 16'h0000 : model(c);
    start_i = 1'b1;
    write_i = w;
    code_i = c;
    wdata_i = d;
    @(posedge clk_i);
    #2;
    start_i = 1'b0;
    check({15'h0000, busy_o}, 16'h0001);
    wait_hi(done_o, 8);
    check({15'h0000, busy_o}, 16'h0000);
    check(rdata_o, e);
    check({15'h0000, err_o}, {15'h0000, er});
    m_cml[6] = m_cml[6] | (w & roc);
    m_cml[7] = m_cml[7] | (er & !(w & roc));
    if (w && c == 8'h00) m_page = d[7:0];
    if (w && c == 8'h04) m_phase = d[7:0];
    if (w && c == 8'h03) m_cml = 8'h00;
    check({14'h0000, alert_o, host_alert_output_o}, {14'h0000, {2{|m_cml}}});
    @(posedge clk_i);
    #2;
  endtask

  always @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      ci <= 16'h0000;
      cs <= 16'h0000;
    end
    else
    begin
      ci <= iin_tick_o ? 16'h0001 : ci + 16'h0001;
      cs <= slow_tick_o ? 16'h0001 : cs + 16'h0001;
      if (iin_tick_o && ci != 16'h0000) check(ci, 16'(`PTR_IIN_CYCLES));
      if (slow_tick_o && cs != 16'h0000) check(cs, 16'h0008);
    end

  initial
  begin
    rnd = 16'h003f;
    roll();
    iin = lfsr(rnd);
    s_iin = iin;
    m_page = 8'h00;
    m_phase = 8'h00;
    m_cml = 8'h00;
    repeat (20) @(posedge clk_i);
    #2 reset_n_i = 1'b1;
    op(1'b1, 8'h04, 16'h0001);
    repeat (3)
    begin
      roll();
      repeat (10) @(posedge clk_i);
      foreach (pg[i])
      begin
        op(1'b1, 8'h00, {8'h00, pg[i]});
        foreach (rd[j]) op(1'b0, rd[j], 16'h0000);
      end
    end
    $display("paging test done");
    op(1'b1, 8'h00, 16'h0000);
    foreach (phs[i])
    begin
      op(1'b1, 8'h04, {8'h00, phs[i]});
      op(1'b0, 8'h8c, 16'h0000);
    end
    $display("phase test done");
    foreach (ro[i])
    begin
      op(1'b1, ro[i], rnd);
      op(1'b0, 8'h7e, 16'h0000);
      op(1'b0, 8'h79, 16'h0000);
      op(1'b1, 8'h03, 16'h0000);
    end
    op(1'b0, 8'h55, 16'h0000);
    op(1'b0, 8'h7e, 16'h0000);
    op(1'b1, 8'h03, 16'h0000);
    $display("fault test done");
    wait_hi(iin_tick_o, 4100);
    @(posedge clk_i);
    #2;
    iin = lfsr(iin);
    op(1'b0, 8'h89, 16'h0000);
    repeat (4000) @(posedge clk_i);
    s_iin = iin;
    op(1'b0, 8'h89, 16'h0000);
    $display("refresh test done");
    end_sim();
  end
endmodule // pmbus_telemetry_readback_tb
